// File: design/swwg_regs.svh
// Register map, field positions, reset values and segment times of the
// single-wire waveform generator. Assumes a 32-bit APB slave, byte addresses.
`ifndef SWWG_REGS_SVH
`define SWWG_REGS_SVH

// Register byte offsets
`define SWWG_CTRL_OFS      8'h00
`define SWWG_CMD_OFS       8'h04
`define SWWG_STATUS_OFS    8'h08
`define SWWG_INT_STAT_OFS  8'h0c
`define SWWG_INT_MASK_OFS  8'h10

// Control register fields
`define SWWG_CTRL_SPEED    1:0
`define SWWG_CTRL_W1LT     4:2
`define SWWG_CTRL_DSO      7:5
`define SWWG_CTRL_PPD      10:8
`define SWWG_CTRL_SPUD     13:11
`define SWWG_CTRL_RST      32'h0000_0000

// Command register fields
`define SWWG_CMD_DATA      7:0
`define SWWG_CMD_OP        10:8
`define SWWG_TERM_CODE     8'hf1
`define SWWG_INF_CODE      3'h7

// Response bytes
`define SWWG_RESP_RST_BASE 6'h32
`define SWWG_RESP_PULSE    8'hed

// Time base
`define SWWG_US_NS         1000
`define SWWG_CLK_NS        4

// Segment times in microseconds, regular (also the flexible base) and overdrive
`define SWWG_RSTL_US       512
`define SWWG_RSTL_OD_US    64
`define SWWG_SI_US         8
`define SWWG_SI_OD_US      2
`define SWWG_PDT_US        64
`define SWWG_PDT_OD_US     8
`define SWWG_FILL_US       512
`define SWWG_FILL_OD_US    64
`define SWWG_SHORT_US      4096
`define SWWG_W1L_US        8
`define SWWG_W1L_OD_US     1
`define SWWG_DSO_US        3
`define SWWG_DSO_OD_US     1
`define SWWG_H1_US         49
`define SWWG_H1_OD_US      8
`define SWWG_W0L_US        57
`define SWWG_W0L_OD_US     7
`define SWWG_REC0_US       3

// Pulse durations in microseconds
`define SWWG_PPD_BASE_US   32
`define SWWG_SPUD0_US      16400
`define SWWG_SPUD1_US      65500
`define SWWG_SPUD2_US      131000
`define SWWG_SPUD3_US      262000
`define SWWG_SPUD4_US      524000
`define SWWG_SPUD5_US      1048000
`define SWWG_SPUD6_US      2096000

`endif

// File: design/swwg_pkg.sv
// Types of the single-wire waveform generator: bus carriers, states, state.
// Assumes the constants of swwg_regs.svh for field meaning.
package swwg_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } swwg_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } swwg_apb_rsp_t;

    // Command operations
    typedef enum logic [2:0] {
        SWWG_OP_RESET = 3'h0,
        SWWG_OP_BIT   = 3'h1,
        SWWG_OP_BYTE  = 3'h2,
        SWWG_OP_SPU   = 3'h3,
        SWWG_OP_PROG  = 3'h4,
        SWWG_OP_TERM  = 3'h5
    } swwg_op_t;

    // Sequencer states, one-hot
    typedef enum logic [9:0] {
        SWWG_IDLE    = 10'h001,
        SWWG_RST_LOW = 10'h002,
        SWWG_RST_SI  = 10'h004,
        SWWG_RST_PDT = 10'h008,
        SWWG_RST_4K  = 10'h010,
        SWWG_RST_FIL = 10'h020,
        SWWG_SL_LOW  = 10'h040,
        SWWG_SL_SMP  = 10'h080,
        SWWG_SL_HIGH = 10'h100,
        SWWG_PULSE   = 10'h200
    } swwg_state_t;

    // Reset result codes
    typedef enum logic [1:0] {
        SWWG_RC_SHORT = 2'h0,
        SWWG_RC_PRES  = 2'h1,
        SWWG_RC_ALARM = 2'h2,
        SWWG_RC_NONE  = 2'h3
    } swwg_rcode_t;

    // Whole module state
    typedef struct packed {
        swwg_state_t st;
        logic [11:0] tick_cnt;
        logic [21:0] us_cnt;
        logic        bit_val;
        logic [7:0]  shreg;
        logic [3:0]  bits_left;
        logic        single;
        swwg_rcode_t code;
        logic        pulse_inf;
        logic        pulse_prog;
        logic [7:0]  resp;
        logic [13:0] ctrl;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic [31:0] prdata;
        logic [2:0]  sync;
        logic        lvl;
    } swwg_state_rec_t;

endpackage : swwg_pkg

// File: design/swwg_top.sv
// Single-wire bus waveform generator with APB register access.
// Assumes an open-drain bus with external pull-up and one 250 MHz clock.
`timescale 1ns/1ps
`include "swwg_regs.svh"

module swwg_top #(
    parameter int TICK_CYCLES = `SWWG_US_NS / `SWWG_CLK_NS  // Clock cycles per microsecond
) (
    input  wire logic                    REF_CLK_IN,   // 250 MHz clock
    input  wire logic                    RESET_N_IN,   // Synchronous reset, low
    input  wire swwg_pkg::swwg_apb_req_t APB_REQ_IN,   // APB request
    output swwg_pkg::swwg_apb_rsp_t      APB_RSP_OUT,  // APB answer
    input  wire logic                    BUS_IN,       // Bus level from pin
    output logic                         BUS_OUT,      // Bus drive value
    output logic                         BUS_OE_OUT,   // Bus pull-down enable
    output logic                         SPU_OUT,      // Strong pull-up enable
    output logic                         PROG_OUT,     // Programming voltage enable
    output logic                         IRQ_OUT       // Interrupt, high level
);
    import swwg_pkg::*;

    swwg_state_rec_t q;            // Registered state
    swwg_state_rec_t d;            // Next state

    // Decoded speed and flexible codes
    logic        flex;             // Flexible speed selected
    logic        od;               // Overdrive selected
    logic [21:0] t_rstl;           // reset_low_time
    logic [21:0] t_si;             // short_sample_offset
    logic [21:0] t_pdt;            // presence_sample_offset
    logic [21:0] t_fill;           // fill_delay
    logic [21:0] t_w1l;            // one_low_time
    logic [21:0] t_dso;            // read_sample_offset
    logic [21:0] t_h1;             // one_high_time
    logic [21:0] t_w0l;            // zero_low_time
    logic [21:0] t_rec0;           // zero_recovery_time
    logic [21:0] t_pulse;          // Selected pulse duration
    logic [2:0]  pcode;            // Selected pulse duration code
    logic        tick_hit;         // One microsecond elapsed
    logic        seg_done;         // Current segment expires now
    logic        apb_acc;          // APB access phase
    logic        apb_wr;           // APB write takes effect
    logic        cmd_wr;           // Command register written
    logic        adr_ok;           // Address is mapped
    logic [2:0]  op;               // Written operation
    logic        bit_end;          // A time slot finishes now
    logic        rd_bit;           // Bit read in that slot
    logic [7:0]  sh_next;          // Shift register after the slot
    logic        ev_done;          // Response produced this cycle
    logic        ev_short;         // Short found this cycle

    // Strong pull-up duration lookup in microseconds
    function automatic logic [21:0] spud_us(input logic [2:0] c);
        case (c)
            3'h0:    spud_us = 22'(`SWWG_SPUD0_US);
            3'h1:    spud_us = 22'(`SWWG_SPUD1_US);
            3'h2:    spud_us = 22'(`SWWG_SPUD2_US);
            3'h3:    spud_us = 22'(`SWWG_SPUD3_US);
            3'h4:    spud_us = 22'(`SWWG_SPUD4_US);
            3'h5:    spud_us = 22'(`SWWG_SPUD5_US);
            default: spud_us = 22'(`SWWG_SPUD6_US);
        endcase
    endfunction : spud_us

    // Segment durations per speed mode
    always_comb begin
        flex    = (q.ctrl[`SWWG_CTRL_SPEED] == 2'h1);
        od      = (q.ctrl[`SWWG_CTRL_SPEED] == 2'h2);
        t_rstl  = od ? 22'(`SWWG_RSTL_OD_US) : 22'(`SWWG_RSTL_US);
        t_si    = od ? 22'(`SWWG_SI_OD_US) : 22'(`SWWG_SI_US);
        t_pdt   = od ? 22'(`SWWG_PDT_OD_US) : 22'(`SWWG_PDT_US);
        t_fill  = od ? 22'(`SWWG_FILL_OD_US) : 22'(`SWWG_FILL_US);
        t_h1    = od ? 22'(`SWWG_H1_OD_US) : 22'(`SWWG_H1_US);
        t_w0l   = od ? 22'(`SWWG_W0L_OD_US) : 22'(`SWWG_W0L_US);
        // Flexible speed adds the value code to the base time
        if (od) begin
            t_w1l  = 22'(`SWWG_W1L_OD_US);
            t_dso  = 22'(`SWWG_DSO_OD_US);
            t_rec0 = 22'(`SWWG_REC0_US);
        end else if (flex) begin
            t_w1l  = 22'(`SWWG_W1L_US) + 22'(q.ctrl[`SWWG_CTRL_W1LT]);
            t_dso  = 22'(`SWWG_DSO_US) + 22'(q.ctrl[`SWWG_CTRL_DSO]);
            t_rec0 = t_dso;
        end else begin
            t_w1l  = 22'(`SWWG_W1L_US);
            t_dso  = 22'(`SWWG_DSO_US);
            t_rec0 = 22'(`SWWG_REC0_US);
        end
    end

    // Microsecond tick and segment expiry
    // A segment of N microseconds ends on the edge of its last tick, so
    // every segment is exactly N ticks long and the next one follows
    // without a spare cycle in between.
    assign tick_hit = (q.tick_cnt == 12'(TICK_CYCLES - 1));
    assign seg_done = tick_hit && (q.us_cnt == 22'h1);

    // APB decode
    // Ready is tied high, so the access phase always lasts one cycle;
    // a write to an unmapped address is answered with an error and dropped.
    assign apb_acc = APB_REQ_IN.psel && APB_REQ_IN.penable;
    assign apb_wr  = apb_acc && APB_REQ_IN.pwrite && adr_ok;
    assign op      = APB_REQ_IN.pwdata[`SWWG_CMD_OP];
    assign cmd_wr  = apb_wr && (APB_REQ_IN.paddr == `SWWG_CMD_OFS);

    // Mapped address check
    always_comb begin
        case (APB_REQ_IN.paddr)
            `SWWG_CTRL_OFS, `SWWG_CMD_OFS, `SWWG_STATUS_OFS,
            `SWWG_INT_STAT_OFS, `SWWG_INT_MASK_OFS: adr_ok = 1'b1;
            default:                                 adr_ok = 1'b0;
        endcase
    end

    // Pulse code and duration for a pulse command
    always_comb begin
        pcode = (op == SWWG_OP_PROG) ? q.ctrl[`SWWG_CTRL_PPD] : q.ctrl[`SWWG_CTRL_SPUD];
        if (op == SWWG_OP_PROG) begin
            t_pulse = 22'(`SWWG_PPD_BASE_US) << pcode;
        end else begin
            t_pulse = spud_us(pcode);
        end
    end

    // Next-state logic
    always_comb begin
        d        = q;
        bit_end  = 1'b0;
        rd_bit   = 1'b0;
        ev_done  = 1'b0;
        ev_short = 1'b0;
        // Input synchroniser, level moves when stages two and three agree
        // Sampled level lags the pin by about four cycles, so a segment
        // shorter than that would still see the old bus level.
        d.sync = {q.sync[1:0], BUS_IN};
        if (q.sync[2] == q.sync[1]) begin
            d.lvl = q.sync[2];
        end
        // Free-running tick within a segment
        d.tick_cnt = tick_hit ? 12'h0 : q.tick_cnt + 12'h1;
        if (tick_hit && (q.us_cnt != 22'h0)) begin
            d.us_cnt = q.us_cnt - 22'h1;
        end
        // Sequencer
        case (q.st)
            SWWG_IDLE: begin
                // Commands are taken only while idle
                // A command written while busy is dropped silently, except
                // the termination byte during an endless pulse.
                if (cmd_wr) begin
                    d.tick_cnt = 12'h0;
                    case (op)
                        SWWG_OP_RESET: begin
                            d.st     = SWWG_RST_LOW;
                            d.us_cnt = t_rstl;
                        end
                        SWWG_OP_BIT, SWWG_OP_BYTE: begin
                            d.shreg     = APB_REQ_IN.pwdata[`SWWG_CMD_DATA];
                            d.single    = (op == SWWG_OP_BIT);
                            d.bits_left = (op == SWWG_OP_BIT) ? 4'h1 : 4'h8;
                            d.bit_val   = APB_REQ_IN.pwdata[0];
                            d.st        = SWWG_SL_LOW;
                            d.us_cnt    = APB_REQ_IN.pwdata[0] ? t_w1l : t_w0l;
                        end
                        SWWG_OP_SPU, SWWG_OP_PROG: begin
                            // Disarmed pulse starts at once
                            d.st         = SWWG_PULSE;
                            d.pulse_prog = (op == SWWG_OP_PROG);
                            d.pulse_inf  = (pcode == `SWWG_INF_CODE);
                            d.us_cnt     = t_pulse;
                        end
                        default: begin
                            d.st = SWWG_IDLE;                        // Stray term ignored
                        end
                    endcase
                end
            end
            SWWG_RST_LOW: begin
                if (seg_done) begin
                    d.st     = SWWG_RST_SI;
                    d.us_cnt = t_si;
                end
            end
            SWWG_RST_SI: begin
                // Same test at every speed
                if (seg_done) begin
                    d.st     = q.lvl ? SWWG_RST_PDT : SWWG_RST_4K;
                    d.us_cnt = q.lvl ? t_pdt : 22'(`SWWG_SHORT_US);
                end
            end
            SWWG_RST_PDT: begin
                if (seg_done) begin
                    d.code   = q.lvl ? SWWG_RC_NONE : SWWG_RC_PRES;
                    d.st     = SWWG_RST_FIL;
                    d.us_cnt = t_fill;
                end
            end
            SWWG_RST_4K: begin
                if (seg_done && !q.lvl) begin
                    d.resp   = {`SWWG_RESP_RST_BASE, SWWG_RC_SHORT};
                    d.st     = SWWG_IDLE;
                    ev_done  = 1'b1;
                    ev_short = 1'b1;
                end else if (seg_done) begin
                    d.code   = SWWG_RC_ALARM;
                    d.st     = SWWG_RST_FIL;
                    d.us_cnt = t_fill;
                end
            end
            SWWG_RST_FIL: begin
                if (seg_done) begin
                    d.resp  = {`SWWG_RESP_RST_BASE, q.code};
                    d.st    = SWWG_IDLE;
                    ev_done = 1'b1;
                end
            end
            SWWG_SL_LOW: begin
                if (seg_done) begin
                    d.st     = SWWG_SL_SMP;
                    d.us_cnt = q.bit_val ? t_dso : t_rec0;
                end
            end
            SWWG_SL_SMP: begin
                // Write-1 samples here, write-0 recovery ends the slot
                if (seg_done && q.bit_val) begin
                    d.shreg[0] = q.lvl;
                    d.st       = SWWG_SL_HIGH;
                    d.us_cnt   = t_h1;
                end else if (seg_done) begin
                    bit_end = 1'b1;
                end
            end
            SWWG_SL_HIGH: begin
                if (seg_done) begin
                    bit_end = 1'b1;
                    rd_bit  = q.shreg[0];
                end
            end
            SWWG_PULSE: begin
                // Predefined expiry or termination byte ends the pulse
                if ((seg_done && !q.pulse_inf) ||
                    (q.pulse_inf && cmd_wr && (op == SWWG_OP_TERM) &&
                     (APB_REQ_IN.pwdata[`SWWG_CMD_DATA] == `SWWG_TERM_CODE))) begin
                    d.resp  = `SWWG_RESP_PULSE;
                    d.st    = SWWG_IDLE;
                    ev_done = 1'b1;
                end
            end
            default: begin
                d.st = SWWG_IDLE;
            end
        endcase
        // Slot completion, next slot follows with no gap
        sh_next = {rd_bit, q.shreg[7:1]};
        if (bit_end) begin
            d.shreg     = sh_next;
            d.bits_left = q.bits_left - 4'h1;
            d.tick_cnt  = 12'h0;
            if (q.bits_left == 4'h1) begin
                d.resp  = q.single ? {7'h0, rd_bit} : sh_next;
                d.st    = SWWG_IDLE;
                ev_done = 1'b1;
            end else begin
                d.bit_val = sh_next[0];
                d.st      = SWWG_SL_LOW;
                d.us_cnt  = sh_next[0] ? t_w1l : t_w0l;
            end
        end
        // Register writes
        if (apb_wr && (APB_REQ_IN.paddr == `SWWG_CTRL_OFS)) begin
            d.ctrl = APB_REQ_IN.pwdata[13:0];
        end
        if (apb_wr && (APB_REQ_IN.paddr == `SWWG_INT_MASK_OFS)) begin
            d.int_mask = APB_REQ_IN.pwdata[1:0];
        end
        // Sticky events, a set beats a same-cycle clear
        d.int_stat = q.int_stat;
        if (apb_wr && (APB_REQ_IN.paddr == `SWWG_INT_STAT_OFS)) begin
            d.int_stat = q.int_stat & ~APB_REQ_IN.pwdata[1:0];
        end
        d.int_stat = d.int_stat | {ev_short, ev_done};
        // Read data latched in the setup phase
        if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
            case (APB_REQ_IN.paddr)
                `SWWG_CTRL_OFS:     d.prdata = {18'h0, q.ctrl};
                `SWWG_STATUS_OFS:   d.prdata = {16'h0, q.resp, 5'h0, q.lvl,
                                                (q.st == SWWG_PULSE), (q.st != SWWG_IDLE)};
                `SWWG_INT_STAT_OFS: d.prdata = {30'h0, q.int_stat};
                `SWWG_INT_MASK_OFS: d.prdata = {30'h0, q.int_mask};
                default:            d.prdata = 32'h0;
            endcase
        end
    end

    // State register
    // Synchronous reset; the sync chain starts at the released high level
    // so that no false low is seen straight after reset.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            q            <= '0;
            q.st         <= SWWG_IDLE;
            q.code       <= SWWG_RC_NONE;
            q.ctrl       <= 14'(`SWWG_CTRL_RST);
            q.sync       <= 3'h7;
            q.lvl        <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs; slew control is not applied to pulse edges
    // Bus value stays zero: the pin is open drain, only its enable moves.
    always_comb begin
        APB_RSP_OUT.prdata  = q.prdata;
        APB_RSP_OUT.pready  = 1'b1;
        APB_RSP_OUT.pslverr = apb_acc && !adr_ok;
        BUS_OUT    = 1'b0;
        BUS_OE_OUT = (q.st == SWWG_RST_LOW) || (q.st == SWWG_SL_LOW);
        SPU_OUT    = (q.st == SWWG_PULSE) && !q.pulse_prog;
        PROG_OUT   = (q.st == SWWG_PULSE) && q.pulse_prog;
        IRQ_OUT    = |(q.int_stat & q.int_mask);
    end

endmodule : swwg_top

// File: sim/swwg_properties.sv
// Port checker of the single-wire waveform generator.
// Assumes binding into swwg_top; one clock domain.
`timescale 1ns/1ps
`include "swwg_regs.svh"
module swwg_properties #(
    parameter int TICK_CYCLES = 2  // Cycles per microsecond
) (
    input wire logic                    REF_CLK_IN,  // Clock
    input wire logic                    RESET_N_IN,  // Reset, low
    input wire swwg_pkg::swwg_apb_req_t APB_REQ_IN,  // APB request
    input wire logic                    BUS_OUT,     // Drive value
    input wire logic                    BUS_OE_OUT,  // Pull-down enable
    input wire logic                    SPU_OUT,     // Strong pull-up
    input wire logic                    PROG_OUT,    // Programming pulse
    input wire logic                    IRQ_OUT      // Interrupt
);
    import swwg_pkg::*;
    logic [15:0] low_q;   // Length of running pull-down
    logic [15:0] rel_q;   // Cycles since bus release
    logic        cmd_q;   // Command write taken last edge
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // Run counters and command-write flag
    always_ff @(posedge REF_CLK_IN) begin
        low_q <= (!RESET_N_IN || !BUS_OE_OUT) ? 16'h0 : low_q + 16'h1;
        rel_q <= (!RESET_N_IN || BUS_OE_OUT) ? 16'h0 : rel_q + {15'h0, rel_q != 16'hffff};
        cmd_q <= APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite
                 && APB_REQ_IN.paddr == `SWWG_CMD_OFS;
    end
    drive_zero_a: assert property (BUS_OUT == 1'b0)
        else $error("bus drive value not zero");
    low_min_a: assert property ($fell(BUS_OE_OUT) |-> low_q >= TICK_CYCLES)
        else $error("pull-down shorter than one microsecond");
    low_max_a: assert property (BUS_OE_OUT |-> low_q < 512 * TICK_CYCLES + 1)
        else $error("pull-down longer than reset low time");
    pulse_no_bus_a: assert property ((SPU_OUT || PROG_OUT) |-> !BUS_OE_OUT)
        else $error("bus pulled low during pulse");
    one_pulse_a: assert property (SPU_OUT |-> !PROG_OUT)
        else $error("pull-up and programming pulse together");
    pulse_start_a: assert property ($rose(SPU_OUT || PROG_OUT) |-> cmd_q)
        else $error("pulse began without command");
    resp_idle_a: assert property ($rose(IRQ_OUT) |-> !BUS_OE_OUT && !SPU_OUT && !PROG_OUT)
        else $error("response while bus busy");
    recov_gap_a: assert property ($rose(IRQ_OUT) |-> rel_q >= 3 * TICK_CYCLES - 1)
        else $error("response before recovery ended");
    cover property ($rose(SPU_OUT));
    cover property ($rose(PROG_OUT));
    cover property ($rose(IRQ_OUT));
endmodule : swwg_properties

bind swwg_top swwg_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .APB_REQ_IN(APB_REQ_IN),
    .BUS_OUT(BUS_OUT), .BUS_OE_OUT(BUS_OE_OUT), .SPU_OUT(SPU_OUT),
    .PROG_OUT(PROG_OUT), .IRQ_OUT(IRQ_OUT));

// File: sim/swwg_slave.sv
// Behavioural slave on the single-wire bus.
// Assumes it sees the master's pull-down; T cycles a microsecond.
`timescale 1ns/1ps
module swwg_slave #(
    parameter int T = 2  // Cycles per microsecond
) (
    input  wire logic       clk_in,   // Bench clock
    input  wire logic       oe_in,    // Master pulls low
    input  wire logic [2:0] mode_in,  // 1 presence 2 short 3 alarm 4 zeros
    output logic            pd_out    // Slave pulls low
);
    int   low_n = 0;       // Running low length
    int   since = 0;       // Cycles since release
    logic was_rst = 1'b0;  // Last low was a reset
    // Track master lows and release time
    always @(posedge clk_in) begin
        if (oe_in) begin
            low_n <= low_n + 1;
            since <= 0;
        end else begin
            if (low_n != 0) was_rst <= low_n > 60 * T;
            low_n <= 0;
            since <= since + 1;
        end
    end
    // Pull-down pattern per behaviour
    always_comb begin
        case (mode_in)
            3'h1: pd_out = was_rst && !oe_in && since >= 15 * T && since < 120 * T;
            3'h2: pd_out = 1'b1;
            3'h3: pd_out = was_rst && !oe_in && since < 1000 * T;
            3'h4: pd_out = !was_rst && !oe_in && since < 6 * T;
            default: pd_out = 1'b0;
        endcase
    end
endmodule : swwg_slave

// File: sim/single_wire_waveform_gen_test.sv
// Self-checking bench of the single-wire waveform generator.
// Assumes swwg_top, swwg_slave and a bus with pull-up.
`timescale 1ns/1ps
`include "swwg_regs.svh"
module single_wire_waveform_gen_test;
    import swwg_pkg::*;
    localparam int T = 5;         // Cycles per microsecond, covers sync lag
    logic          clk, rst_n;    // Clock, reset
    swwg_apb_req_t req;           // APB request
    swwg_apb_rsp_t rsp;           // APB answer
    logic          oe, bo, spu, prog, irq, pd, prv;  // Pins, slave pull
    logic [2:0]    mode;          // Slave behaviour
    logic [31:0]   rd;            // Last read data
    logic          err;           // Last error flag
    int            miscompares, tests_run, cyc, run, sr, plen;
    int            lows[$], highs[$];  // Bus run lengths
    swwg_top #(.TICK_CYCLES(T)) dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
        .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .BUS_IN((oe ? bo : 1'b1) & !pd), .BUS_OUT(bo),
        .BUS_OE_OUT(oe), .SPU_OUT(spu), .PROG_OUT(prog), .IRQ_OUT(irq));
    swwg_slave #(.T(T)) slave (.clk_in(clk), .oe_in(oe), .mode_in(mode), .pd_out(pd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Bus run lengths, pulse length, timeout
    always @(posedge clk) begin
        if (oe === prv) run++;
        else begin
            if (prv) lows.push_back(run); else highs.push_back(run);
            run = 1;
            prv = oe;
        end
        if (spu | prog) sr++; else if (sr != 0) begin plen = sr; sr = 0; end
        cyc++;
        if (cyc == 100000) begin miscompares++; conclude(); end
    end
    task automatic check(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    task automatic run_cmd(input logic [2:0] op, input logic [7:0] d, exp);
        lows.delete();
        highs.delete();
        apb(1'b1, `SWWG_CMD_OFS, {21'h0, op, d});
        while (irq !== 1'b1) @(posedge clk);
        apb(1'b0, `SWWG_STATUS_OFS, 32'h0);
        check("response", rd[15:8], exp);
        apb(1'b0, `SWWG_INT_STAT_OFS, 32'h0);
        check("short flag", rd[1], exp == 8'hc8);
        apb(1'b1, `SWWG_INT_STAT_OFS, 32'h3);
        check("irq clear", irq, 1'b0);
    endtask : run_cmd
    task automatic t_regs();
        apb(1'b0, `SWWG_CTRL_OFS, 32'h0);
        check("ctrl reset", rd, `SWWG_CTRL_RST);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `SWWG_CMD_OFS, {21'h0, SWWG_OP_BIT, 8'h1});
        do apb(1'b0, `SWWG_STATUS_OFS, 32'h0); while (rd[0] !== 1'b0);
        check("masked irq", irq, 1'b0);
        apb(1'b1, `SWWG_INT_MASK_OFS, 32'h3);
        check("unmasked irq", irq, 1'b1);
        apb(1'b1, `SWWG_INT_STAT_OFS, 32'h3);
        check("cleared irq", irq, 1'b0);
    endtask : t_regs
    task automatic t_reset(input logic [31:0] ctl, input logic [2:0] m,
                           input logic [7:0] code, input int low_us);
        apb(1'b1, `SWWG_CTRL_OFS, ctl);
        mode <= m;
        run_cmd(SWWG_OP_RESET, 8'h0, code);
        check("reset low", lows[0], low_us * T);
        mode <= 3'h0;
    endtask : t_reset
    task automatic t_byte(input logic [31:0] ctl, input logic [7:0] d,
                          input int w1, ds, h1, w0, rc);
        apb(1'b1, `SWWG_CTRL_OFS, ctl);
        run_cmd(SWWG_OP_BYTE, d, d);
        for (int i = 0; i < 8; i++) begin
            check("slot low", lows[i], (d[i] ? w1 : w0) * T);
            if (i < 7) check("slot gap", highs[i + 1], (d[i] ? ds + h1 : rc) * T);
        end
    endtask : t_byte
    task automatic t_pulse();
        for (int c = 0; c < 7; c++) begin
            apb(1'b1, `SWWG_CTRL_OFS, c << 8);
            run_cmd(SWWG_OP_PROG, 8'h0, 8'hed);
            check("prog length", plen, (32 << c) * T);
        end
        apb(1'b1, `SWWG_CTRL_OFS, 32'h7 << 11);
        apb(1'b1, `SWWG_CMD_OFS, {21'h0, SWWG_OP_SPU, 8'h0});
        repeat (50) @(posedge clk);
        check("endless pull-up", {irq, spu}, 2'b01);
        run_cmd(SWWG_OP_TERM, `SWWG_TERM_CODE, `SWWG_RESP_PULSE);
        repeat (20) @(posedge clk);
        check("single response", {irq, spu}, 2'b00);
    endtask : t_pulse
    initial begin
        rst_n = 1'b0;
        req = '0;
        mode = 3'h0;
        prv = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_reset(32'h0, 3'h1, 8'hc9, 512);
        t_reset(32'h2, 3'h0, 8'hcb, 64);
        t_reset(32'h2, 3'h2, 8'hc8, 64);
        t_reset(32'h0, 3'h3, 8'hca, 512);
        t_byte(32'h0, 8'ha5, 8, 3, 49, 57, 3);
        t_byte(32'h5d, 8'h5a, 15, 5, 49, 57, 5);
        t_byte(32'h2, 8'h0f, 1, 1, 8, 7, 3);
        apb(1'b1, `SWWG_CTRL_OFS, 32'h0);
        mode <= 3'h4;
        run_cmd(SWWG_OP_BYTE, 8'hff, 8'h00);
        mode <= 3'h0;
        t_pulse();
        conclude();
    end
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
endmodule : single_wire_waveform_gen_test
